/* File: core/ssc_system_control.sv */
// Upper half (bits 31:16) of the system setup control register, two functions.
// Assumes config cycles on mclk and card pins that are asynchronous to it.
//
// What this block does
// - Step field rotates interrupts across serial slots
// - Global fields are one shared copy
// - Tie bit merges INTA and INTB
// - Tie-all merges A, B, C; pin register reports
// - Direction bit drives switch clock out
// - Route bit picks IRQ2 or status change
// - Flag sets on power write while enable bit is set; one clears
// - Enable bit makes power writes signal events
// - Drive reserved terminals low for 32-bit card
// - Protect-disable bit turns supply protection off
// - Reduced video floats address lines 25 to 22
// - Request enable passes card DMA requests
// - Channel field selects DMA channel, 4 unused
// - Marked fields clear only on global reset
`timescale 1ns/100ps

module ssc_system_control
    import ssc_pkg::*;
#(
    parameter int SWCLK_HALF = SSC_SWCLK_HALF
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        pciResetN,
    input  wire logic        cfgWrite,
    input  wire logic        cfgRead,
    input  wire logic        cfgFunc,
    input  wire logic [7:0]  cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWrData,
    output logic      [31:0] cfgRdData,
    output logic             cfgRdValid,
    input  wire logic        intA,
    input  wire logic        intB,
    input  wire logic        intC,
    output logic      [3:0]  serialSlots,
    output logic      [7:0]  intPinFunc0,
    output logic      [7:0]  intPinFunc1,
    output logic             switchClockOut,
    output logic             switchClockOe,
    input  wire logic [1:0]  socketPowerWrite,
    output logic             irq2Event,
    output logic      [1:0]  cardStatusChange,
    input  wire logic [1:0]  card32Present,
    output logic      [1:0]  reservedTermOut,
    output logic      [1:0]  reservedTermOe,
    output logic      [1:0]  supplyProtectEnable,
    output logic      [1:0]  cardAddrHighOe,
    input  wire logic [1:0]  cardDmaRequest,
    output logic      [1:0]  dmaRequest,
    output logic      [5:0]  dmaChannel,
    output logic      [1:0]  dmaChannelUsed
);

    // Shared fields (one copy for both functions)
    logic [1:0] irqSlotRotation;
    logic       tieABIrq;
    logic       tieAllIrq;
    logic       switchClockDirection;
    logic       powerEventRoute;
    logic       powerEventEnable;

    // Per-socket fields
    logic [1:0] powerEventFlag;
    logic [1:0] reservedTerminalDrive;
    logic [1:0] supplyProtectDisable;
    logic [1:0] reducedZoomedVideo;
    logic [1:0] cardDmaRequestEnable;
    logic [2:0] dmaChannelSelect [SSC_SOCKETS];

    // Pin synchronisers
    logic       pciRstMeta;
    logic       pciRstSync;
    logic [1:0] card32Meta;
    logic [1:0] card32Sync;
    logic [1:0] dreqMeta;
    logic [1:0] dreqSync;

    // Switch clock divider
    logic [15:0] swClkCount;
    logic        swClkLevel;

    // Decode
    logic        regHit;
    logic        wrHigh;
    logic        wrMid;
    logic [1:0]  sockSel;
    logic [1:0]  flagClear;
    logic [1:0]  flagSet;
    logic [1:0]  next_powerEventFlag;
    logic [31:0] readWord;
    logic [3:0]  steeredSlots;
    logic        tieAny;

    function automatic logic [31:0] pack_word(input logic sock);
        logic [31:0] w;
        w = 32'h0;
        w[SSC_STEP_LSB +: 2]   = irqSlotRotation;
        w[SSC_TIE_AB_BIT]      = tieABIrq;
        w[SSC_TIE_ALL_BIT]     = tieAllIrq;
        w[SSC_CLK_DIR_BIT]     = switchClockDirection;
        w[SSC_ROUTE_BIT]       = powerEventRoute;
        w[SSC_FLAG_BIT]        = powerEventFlag[sock];
        w[SSC_ENABLE_BIT]      = powerEventEnable;
        w[SSC_RSVD_BIT]        = 1'b0;
        w[SSC_RSVD_DRIVE_BIT]  = reservedTerminalDrive[sock];
        w[SSC_PROT_DIS_BIT]    = supplyProtectDisable[sock];
        w[SSC_REDUCED_ZV_BIT]  = reducedZoomedVideo[sock];
        w[SSC_DREQ_EN_BIT]     = cardDmaRequestEnable[sock];
        w[SSC_CHAN_LSB +: 3]   = dmaChannelSelect[sock];
        return w;
    endfunction : pack_word

    assign regHit   = (cfgAddr == SSC_REG_OFFSET);
    assign wrHigh   = cfgWrite & regHit & cfgByteEn[SSC_LANE_HIGH];
    assign wrMid    = cfgWrite & regHit & cfgByteEn[SSC_LANE_MID];
    assign sockSel  = cfgFunc ? 2'h2 : 2'h1;
    // A process, not an assign, so field updates seen inside pack_word re-evaluate it
    always_comb
    begin
        readWord = regHit ? pack_word(cfgFunc) : 32'h0;
    end
    assign tieAny   = tieABIrq | tieAllIrq;

    // Only a written one clears the flag; a new event in the same cycle wins
    assign flagClear = (wrHigh && cfgWrData[SSC_FLAG_BIT]) ? sockSel : 2'h0;
    assign flagSet   = powerEventEnable ? socketPowerWrite : 2'h0;
    assign next_powerEventFlag = flagSet | (powerEventFlag & ~flagClear);

    ssc_irq_steer u_steer (
        .step   (irqSlotRotation),
        .tieAb  (tieABIrq),
        .tie_all_irq (tieAllIrq),
        .intA   (intA),
        .intB   (intB),
        .intC   (intC),
        .slots  (steeredSlots)
    );

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pciRstMeta <= 1'b1;
            pciRstSync <= 1'b1;
            card32Meta <= 2'h0;
            card32Sync <= 2'h0;
            dreqMeta   <= 2'h0;
            dreqSync   <= 2'h0;
        end
        else
        begin
            pciRstMeta <= ~pciResetN;
            pciRstSync <= pciRstMeta;
            card32Meta <= card32Present;
            card32Sync <= card32Meta;
            dreqMeta   <= cardDmaRequest;
            dreqSync   <= dreqMeta;
        end
    end

    // Marked fields: cleared by the global reset only, never by the bus reset
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irqSlotRotation      <= SSC_STEP_RESET;
            tieABIrq             <= 1'b0;
            switchClockDirection <= 1'b0;
            powerEventRoute      <= 1'b0;
            powerEventEnable     <= 1'b0;
        end
        else if (wrHigh)
        begin
            // One shared copy, whichever function writes it
            irqSlotRotation      <= cfgWrData[SSC_STEP_LSB +: 2];
            tieABIrq             <= cfgWrData[SSC_TIE_AB_BIT];
            switchClockDirection <= cfgWrData[SSC_CLK_DIR_BIT];
            powerEventRoute      <= cfgWrData[SSC_ROUTE_BIT];
            powerEventEnable     <= cfgWrData[SSC_ENABLE_BIT];
        end
    end

    // Tie-all carries no global-only mark, so the bus reset clears it too
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tieAllIrq <= 1'b0;
        end
        else if (pciRstSync)
        begin
            tieAllIrq <= 1'b0;
        end
        else if (wrHigh)
        begin
            tieAllIrq <= cfgWrData[SSC_TIE_ALL_BIT];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            powerEventFlag <= 2'h0;
        end
        else
        begin
            powerEventFlag <= next_powerEventFlag;
        end
    end

    for (genvar s = 0; s < SSC_SOCKETS; s++)
    begin : g_sock
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                reservedTerminalDrive[s] <= 1'b0;
                supplyProtectDisable[s]  <= 1'b0;
                reducedZoomedVideo[s]    <= 1'b0;
                cardDmaRequestEnable[s]  <= 1'b0;
                dmaChannelSelect[s]      <= SSC_CHAN_RESET;
            end
            else if (wrMid && sockSel[s])
            begin
                reservedTerminalDrive[s] <= cfgWrData[SSC_RSVD_DRIVE_BIT];
                supplyProtectDisable[s]  <= cfgWrData[SSC_PROT_DIS_BIT];
                reducedZoomedVideo[s]    <= cfgWrData[SSC_REDUCED_ZV_BIT];
                cardDmaRequestEnable[s]  <= cfgWrData[SSC_DREQ_EN_BIT];
                dmaChannelSelect[s]      <= cfgWrData[SSC_CHAN_LSB +: 3];
            end
        end

        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                reservedTermOe[s]      <= 1'b0;
                supplyProtectEnable[s] <= 1'b1;
                cardAddrHighOe[s]      <= 1'b1;
                dmaRequest[s]          <= 1'b0;
                dmaChannel[3*s +: 3]   <= SSC_CHAN_RESET;
                dmaChannelUsed[s]      <= 1'b0;
            end
            else
            begin
                reservedTermOe[s]      <= reservedTerminalDrive[s] & card32Sync[s];
                supplyProtectEnable[s] <= ~supplyProtectDisable[s];
                cardAddrHighOe[s]      <= ~reducedZoomedVideo[s];
                dmaRequest[s]          <= cardDmaRequestEnable[s] & dreqSync[s];
                dmaChannel[3*s +: 3]   <= dmaChannelSelect[s];
                dmaChannelUsed[s]      <= (dmaChannelSelect[s] != SSC_CHAN_UNUSED);
            end
        end
    end

    // Event notification follows the route bit sampled in the event cycle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq2Event        <= 1'b0;
            cardStatusChange <= 2'h0;
        end
        else
        begin
            irq2Event        <= ~powerEventRoute & (|flagSet);
            cardStatusChange <= powerEventRoute ? flagSet : 2'h0;
        end
    end

    // Free-running divider stands in for the internal oscillator
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            swClkCount <= 16'h0;
            swClkLevel <= 1'b0;
        end
        else if (swClkCount == 16'(SWCLK_HALF - 1))
        begin
            swClkCount <= 16'h0;
            swClkLevel <= ~swClkLevel;
        end
        else
        begin
            swClkCount <= swClkCount + 16'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            switchClockOut  <= 1'b0;
            switchClockOe   <= 1'b0;
            serialSlots     <= 4'h0;
            intPinFunc0     <= SSC_PIN_INTA;
            intPinFunc1     <= SSC_PIN_INTB;
            reservedTermOut <= 2'h0;
            cfgRdData       <= 32'h0;
            cfgRdValid      <= 1'b0;
        end
        else
        begin
            switchClockOut  <= swClkLevel;
            switchClockOe   <= switchClockDirection;
            serialSlots     <= steeredSlots;
            intPinFunc0     <= SSC_PIN_INTA;
            intPinFunc1     <= tieAny ? SSC_PIN_INTA : SSC_PIN_INTB;
            // Reserved terminals are only ever driven low
            reservedTermOut <= 2'h0;
            cfgRdData       <= cfgRead ? readWord : 32'h0;
            cfgRdValid      <= cfgRead;
        end
    end

endmodule : ssc_system_control

/* File: core/ssc_pkg.sv */
// Constants for the upper half of the system setup control register.
// Assumes configuration accesses arrive as whole-word cycles with byte enables.
package ssc_pkg;

    // Configuration space byte offset of the register
    localparam logic [7:0] SSC_REG_OFFSET     = 8'h80;

    // Field positions within the 32-bit word
    localparam int         SSC_STEP_LSB       = 30;
    localparam int         SSC_TIE_AB_BIT     = 29;
    localparam int         SSC_TIE_ALL_BIT    = 28;
    localparam int         SSC_CLK_DIR_BIT    = 27;
    localparam int         SSC_ROUTE_BIT      = 26;
    localparam int         SSC_FLAG_BIT       = 25;
    localparam int         SSC_ENABLE_BIT     = 24;
    localparam int         SSC_RSVD_BIT       = 23;
    localparam int         SSC_RSVD_DRIVE_BIT = 22;
    localparam int         SSC_PROT_DIS_BIT   = 21;
    localparam int         SSC_REDUCED_ZV_BIT = 20;
    localparam int         SSC_DREQ_EN_BIT    = 19;
    localparam int         SSC_CHAN_LSB       = 16;

    // Byte lanes that carry the fields
    localparam int         SSC_LANE_HIGH      = 3;
    localparam int         SSC_LANE_MID       = 2;

    // Reset values and the unused channel code
    localparam logic [1:0] SSC_STEP_RESET     = 2'h0;
    localparam logic [2:0] SSC_CHAN_RESET     = 3'h4;
    localparam logic [2:0] SSC_CHAN_UNUSED    = 3'h4;

    // Values for the interrupt pin register of each function
    localparam logic [7:0] SSC_PIN_INTA       = 8'h01;
    localparam logic [7:0] SSC_PIN_INTB       = 8'h02;
    localparam logic [7:0] SSC_PIN_INTC       = 8'h03;

    // Half period of the generated switch clock, in mclk cycles
    localparam int         SSC_SWCLK_HALF     = 4;

    // Number of card sockets, one per card function
    localparam int         SSC_SOCKETS        = 2;

endpackage : ssc_pkg

/* File: core/ssc_irq_steer.sv */
// Merges the internal interrupt lines and rotates them into serial slots.
// Assumes level inputs on the same clock; the result is combinational.
`timescale 1ns/100ps

module ssc_irq_steer
    import ssc_pkg::*;
(
    input  wire logic [1:0] step,
    input  wire logic       tieAb,
    input  wire logic       tie_all_irq,
    input  wire logic       intA,
    input  wire logic       intB,
    input  wire logic       intC,
    output logic      [3:0] slots
);

    logic [2:0] merged;

    // Tie-all takes priority; it also swallows INTB like the plain tie
    assign merged[0] = intA | ((tieAb | tie_all_irq) & intB) | (tie_all_irq & intC);
    assign merged[1] = intB & ~(tieAb | tie_all_irq);
    assign merged[2] = intC & ~tie_all_irq;

    // Line n lands in slot (n + step) mod 4
    always_comb
    begin
        slots = 4'h0;
        for (int n = 0; n < 3; n++)
        begin
            slots[2'(n) + step] = slots[2'(n) + step] | merged[n];
        end
    end

endmodule : ssc_irq_steer

/* File: tb/ssc_host_model.sv */
// Host model that issues configuration cycles to the register block.
// Assumes one access at a time, launched 1 ns after a rising mclk.
`timescale 1ns/100ps

module ssc_host_model
(
    input  wire logic        mclk,
    output logic             cfgWrite,
    output logic             cfgRead,
    output logic             cfgFunc,
    output logic      [7:0]  cfgAddr,
    output logic      [3:0]  cfgByteEn,
    output logic      [31:0] cfgWrData,
    input  wire logic [31:0] cfgRdData,
    input  wire logic        cfgRdValid
);
    initial
    begin
        {cfgWrite, cfgRead, cfgFunc, cfgAddr, cfgByteEn, cfgWrData} = '0;
    end

    task automatic wr(input logic f, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        @(posedge mclk);
        #1;
        {cfgFunc, cfgAddr, cfgByteEn, cfgWrData} = {f, a, be, d};
        cfgWrite = 1'b1;
        @(posedge mclk);
        #1;
        cfgWrite = 1'b0;
        // Released data is scrambled so a late sample cannot look right
        cfgWrData = ~d;
    endtask : wr

    task automatic rd(input logic f, input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        #1;
        {cfgFunc, cfgAddr} = {f, a};
        cfgRead = 1'b1;
        @(posedge mclk);
        #1;
        cfgRead = 1'b0;
        d = cfgRdValid ? cfgRdData : 32'hXXXX_XXXX;
    endtask : rd
endmodule : ssc_host_model

/* File: tb/ssc_checker.sv */
// Checker for the upper half of the system setup control register.
// Bound to ssc_system_control; sees only its ports.
`timescale 1ns/100ps

module ssc_checker
    import ssc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        cfgRead,
    input wire logic [31:0] cfgRdData,
    input wire logic        cfgRdValid,
    input wire logic        intA,
    input wire logic        intB,
    input wire logic        intC,
    input wire logic [3:0]  serialSlots,
    input wire logic [1:0]  socketPowerWrite,
    input wire logic        irq2Event,
    input wire logic [1:0]  cardStatusChange,
    input wire logic [1:0]  reservedTermOut,
    input wire logic [5:0]  dmaChannel,
    input wire logic [1:0]  dmaChannelUsed
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence quietLines;
        !(intA || intB || intC);
    endsequence
    sequence lineAOnly;
        intA && !intB && !intC;
    endsequence

    a_read_answer: assert property (cfgRead |=> cfgRdValid)
        else $error("read not answered");
    a_idle_zero: assert property (!cfgRdValid |-> cfgRdData == 32'h0)
        else $error("read data not zero when idle");
    a_rsvd_zero: assert property (cfgRdValid |-> !cfgRdData[23])
        else $error("reserved bit read as one");
    a_slots_quiet: assert property (quietLines |=> serialSlots == 4'h0)
        else $error("slot raised with no interrupt");
    a_slot_single: assert property (lineAOnly |=> $onehot(serialSlots))
        else $error("single line not in one slot");
    a_route_excl: assert property (!(irq2Event && |cardStatusChange))
        else $error("both event routes raised");
    a_irq2_cause: assert property (irq2Event |-> $past(socketPowerWrite) != 2'h0)
        else $error("event pulse without power write");
    a_csc_cause: assert property (cardStatusChange[1] |->
                                  ($past(socketPowerWrite) & 2'h2) != 2'h0)
        else $error("status change without power write");
    a_term_low: assert property (reservedTermOut == 2'h0)
        else $error("reserved terminals not driven low");
    a_chan_used: assert property (dmaChannelUsed[0] == (dmaChannel[2:0] != SSC_CHAN_UNUSED))
        else $error("channel used flag wrong");
endmodule : ssc_checker

bind ssc_system_control ssc_checker ssc_checker_i (
    .mclk, .rst, .cfgRead, .cfgRdData, .cfgRdValid, .intA, .intB, .intC,
    .serialSlots, .socketPowerWrite, .irq2Event, .cardStatusChange,
    .reservedTermOut, .dmaChannel, .dmaChannelUsed
);

/* File: tb/test_ssc_system_control.sv */
// Testbench for the system setup control upper half.
// Assumes the host model issues every configuration cycle.
`timescale 1ns/100ps

module test_ssc_system_control
    import ssc_pkg::*;
;
    logic        mclk = 1'b0, rst = 1'b1, pciResetN = 1'b1;
    logic        intA = 1'b0, intB = 1'b0, intC = 1'b0;
    logic [1:0]  socketPowerWrite = 2'h0, card32Present = 2'h0, cardDmaRequest = 2'h0;
    logic        cfgWrite, cfgRead, cfgFunc, cfgRdValid, switchClockOut, switchClockOe;
    logic        irq2Event;
    logic [7:0]  cfgAddr, intPinFunc0, intPinFunc1;
    logic [3:0]  cfgByteEn, serialSlots;
    logic [31:0] cfgWrData, cfgRdData;
    logic [1:0]  cardStatusChange, reservedTermOut, reservedTermOe, supplyProtectEnable;
    logic [1:0]  cardAddrHighOe, dmaRequest, dmaChannelUsed;
    logic [5:0]  dmaChannel;
    int          bad_count = 0, num_checks = 0;

    always #20 mclk = ~mclk;

    ssc_system_control #(.SWCLK_HALF(2)) ssc_system_control_i (
        .mclk, .rst, .pciResetN, .cfgWrite, .cfgRead, .cfgFunc, .cfgAddr, .cfgByteEn,
        .cfgWrData, .cfgRdData, .cfgRdValid, .intA, .intB, .intC, .serialSlots,
        .intPinFunc0, .intPinFunc1, .switchClockOut, .switchClockOe, .socketPowerWrite,
        .irq2Event, .cardStatusChange, .card32Present, .reservedTermOut, .reservedTermOe,
        .supplyProtectEnable, .cardAddrHighOe, .cardDmaRequest, .dmaRequest, .dmaChannel,
        .dmaChannelUsed
    );
    ssc_host_model ssc_host_model_i (
        .mclk, .cfgWrite, .cfgRead, .cfgFunc, .cfgAddr, .cfgByteEn, .cfgWrData,
        .cfgRdData, .cfgRdValid
    );

    task automatic wrap_up;
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tk

    task automatic rdc(input logic f, input logic [31:0] exp);
        logic [31:0] d;
        ssc_host_model_i.rd(f, SSC_REG_OFFSET, d);
        check("register", d, exp);
    endtask : rdc

    task automatic wr(input logic f, input logic [3:0] be, input logic [31:0] d);
        ssc_host_model_i.wr(f, SSC_REG_OFFSET, be, d);
    endtask : wr

    // Event pulse lasts one cycle, so the outputs are looked at right after it
    task automatic pulse(input logic [1:0] p, input logic [2:0] exp);
        socketPowerWrite = p;
        tk(1);
        socketPowerWrite = 2'h0;
        check("event", 32'({irq2Event, cardStatusChange}), 32'(exp));
    endtask : pulse

    initial
    begin
        logic [31:0] d;
        logic [1:0]  tie;
        tk(6);
        rst = 1'b0;
        rdc(1'b0, 32'h0004_0000);
        check("pins", 32'({supplyProtectEnable, cardAddrHighOe, dmaChannel, dmaChannelUsed}),
              32'h0000_0F90);
        check("clk", 32'({switchClockOe, intPinFunc1}), 32'h0000_0002);
        // Divided clock holds each level for two mclk edges with SWCLK_HALF of 2
        d[0] = switchClockOut;
        tk(2);
        check("swclk", 32'(switchClockOut ^ d[0]), 32'h1);
        ssc_host_model_i.rd(1'b0, 8'h84, d);
        check("unmapped", d, 32'h0);
        wr(1'b0, 4'hF, 32'hFFFF_FFFF);
        rdc(1'b0, 32'hFD7F_0000);
        check("pins", 32'({supplyProtectEnable, cardAddrHighOe, dmaChannel, dmaChannelUsed}),
              32'h0000_0A9D);
        check("clk", 32'({switchClockOe, intPinFunc1}), 32'h0000_0101);
        check("pin0", 32'(intPinFunc0), 32'(SSC_PIN_INTA));
        rdc(1'b1, 32'hFD04_0000);
        for (int c = 0; c < 8; c++)
        begin
            wr(1'b1, 4'h4, 32'(c) << 16);
            tk(1);
            check("chan", 32'({dmaChannel[5:3], dmaChannelUsed[1]}), 32'({3'(c), c != 4}));
        end
        wr(1'b0, 4'h8, 32'h0);
        rdc(1'b0, 32'h007F_0000);
        for (int s = 0; s < 4; s++)
        begin
            for (int m = 0; m < 5; m++)
            begin
                tie = (m == 3) ? 2'h2 : (m == 4) ? 2'h1 : 2'h0;
                wr(1'b0, 4'h8, {2'(s), tie, 28'h0});
                {intA, intB, intC} = 3'h4 >> (m < 3 ? m : m - 2);
                tk(2);
                check("slots", 32'(serialSlots), 32'(4'h1 << (((m < 3 ? m : 0) + s) % 4)));
                {intA, intB, intC} = 3'h0;
            end
        end
        wr(1'b0, 4'h8, 32'h0100_0000);
        pulse(2'h1, 3'h4);
        rdc(1'b0, 32'h037F_0000);
        wr(1'b0, 4'h8, 32'h0500_0000);
        rdc(1'b0, 32'h077F_0000);
        pulse(2'h2, 3'h2);
        wr(1'b0, 4'h8, 32'h0200_0000);
        rdc(1'b0, 32'h007F_0000);
        pulse(2'h3, 3'h0);
        rdc(1'b1, 32'h0207_0000);
        wr(1'b1, 4'h8, 32'h0200_0000);
        rdc(1'b1, 32'h0007_0000);
        {card32Present, cardDmaRequest} = 4'hF;
        tk(5);
        check("card", 32'({reservedTermOe, dmaRequest}), 32'h5);
        {card32Present, cardDmaRequest} = 4'h0;
        tk(5);
        check("card", 32'({reservedTermOe, dmaRequest}), 32'h0);
        wr(1'b0, 4'h8, 32'h3000_0000);
        pciResetN = 1'b0;
        tk(4);
        pciResetN = 1'b1;
        tk(1);
        rdc(1'b0, 32'h207F_0000);
        rst = 1'b1;
        tk(2);
        rst = 1'b0;
        rdc(1'b0, 32'h0004_0000);
        wrap_up();
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        wrap_up();
    end
endmodule : test_ssc_system_control
